// [dcap_ctrl_model.sv]
// memory controller model driving link clock, command, address, termination and mask pins
`include "dcap_defs.svh"
module dcap_ctrl_model (
  // timing reference
  input wire logic clk_sys,
  // link pins
  output logic ck,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [`DCAP_BANK_W-1:0] ba,
  output logic [`DCAP_ADDR_W-1:0] addr,
  output logic odt,
  output logic ldm,
  output logic udm
);
  timeunit 1ns;
  timeprecision 1ns;
  // link clock stands still between frames, so the design never sees free-running edges
  int edges = 0;
  initial begin
    ck = 0;
    cke = 1;
    cs_n = 1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = 3'h0;
    addr = 16'h0000;
    odt = 0;
    ldm = 0;
    udm = 0;
  end
  task automatic drive(input logic c, input logic [2:0] rcw, input logic [2:0] b,
                       input logic [15:0] a, input logic e, input logic t);
    @(negedge clk_sys);
    cs_n = c;
    {ras_n, cas_n, we_n} = rcw;
    ba = b;
    addr = a;
    cke = e;
    odt = t;
  endtask
  task automatic pulse();
    repeat (`DCAP_LINK_CYCLES / 2) @(negedge clk_sys);
    ck = 1;
    edges++;
    repeat (`DCAP_LINK_CYCLES / 2) @(negedge clk_sys);
    ck = 0;
    edges++;
    // released lines: deselect and invert so a stale value never passes for a fresh one
    cs_n = 1;
    ba = ~ba;
    addr = ~addr;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic set_mask(input logic lo, input logic hi);
    @(negedge clk_sys);
    ldm = lo;
    udm = hi;
  endtask
endmodule

// [dcap_defs.svh]
// constants for the dram command and address port
// Operation
// - activate carries the row address; read and write carry the column address.
// - on read and write, address bit 10 requests auto precharge, not a column bit.
// - on precharge, bit 10 low closes the addressed bank, high closes every bank.
// - on load mode, the address inputs carry the op-code for a mode register.
// - with on-the-fly chop enabled, bit 12 high gives burst eight, low gives four.
// - bank inputs pick the bank for activate, read, write and precharge.
// - on load mode, bank inputs pick mode register zero to three.
// - all control and address inputs are sampled at the rising clock crossing.
// - the output strobe reference follows the differential clock crossings.
// - clock enable high runs the device; low enters power-down or self refresh.
// - clock enable is sampled for entries and power-down exit; self refresh exit is clockless.
// - power-down listens only to clock, enable, reset, termination; self refresh less.
// - chip select low enables decoding; high masks every command.
// - the command code is chip select with row, column and write strobes together.
// - a lower byte beat with its mask high is not stored.
// - termination follows its input and covers sixteen data lines, strobes and masks.
// - x8 adds termination strobes when enabled; x4 covers four lines, strobe, mask.
// - termination input is ignored once disabled through load mode.
// - an upper byte beat with its mask high is not stored.
// - reset is active low, asserted and released without the clock.
`ifndef DCAP_DEFS_SVH
`define DCAP_DEFS_SVH

`define DCAP_ADDR_W 16
`define DCAP_BANK_W 3
`define DCAP_NUM_BANKS 8
`define DCAP_NUM_MR 4
`define DCAP_COL_W 10
`define DCAP_DQ_W 16
`define DCAP_AP_BIT 10
`define DCAP_BC_BIT 12
`define DCAP_SYNC_W 28
// mode register fields steering this port
`define DCAP_OTF_MR 2'h0
`define DCAP_OTF_BIT 0
`define DCAP_ODT_MR 2'h1
`define DCAP_ODT_BIT 2
`define DCAP_TDQS_BIT 11
// data width organisation: 4, 8 or 16
`define DCAP_ORG 16
// reset values
`define DCAP_MR_RST 16'h0000
`define DCAP_ODT_EN_RST 1'b1
// link clock period in ns, system clock period in ns
`define DCAP_LINK_PERIOD_NS 800
`define DCAP_SYS_PERIOD_NS 100
`define DCAP_LINK_CYCLES (`DCAP_LINK_PERIOD_NS / `DCAP_SYS_PERIOD_NS)

`endif

// [dcap_pkg.sv]
// types shared by the dram command and address port
package dcap_pkg;
  typedef enum logic [3:0] {
    CMD_DESEL,
    CMD_NOP,
    CMD_ACT,
    CMD_READ,
    CMD_WRITE,
    CMD_PRE,
    CMD_REF,
    CMD_LMR,
    CMD_ZQ
  } dcap_cmd_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_PRE_PD,
    PWR_ACT_PD,
    PWR_SELF_REF
  } dcap_pwr_t;
endpackage

// [dcap_port.sv]
// command, address and control input port of a x16 ddr dram
`include "dcap_defs.svh"

module dcap_port (
  // system
  input wire logic clk_sys,
  input wire logic resetn,
  // link pins from the memory controller
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [`DCAP_BANK_W-1:0] ba,
  input wire logic [`DCAP_ADDR_W-1:0] addr,
  input wire logic odt,
  input wire logic ldm,
  input wire logic udm,
  // write data beat from the data path
  input wire logic wr_beat,
  // decoded command
  output logic cmd_valid,
  output dcap_pkg::dcap_cmd_t cmd_code,
  output logic [`DCAP_BANK_W-1:0] cmd_bank,
  output logic [`DCAP_ADDR_W-1:0] row_addr,
  output logic [`DCAP_COL_W-1:0] col_addr,
  output logic auto_pre,
  output logic pre_all,
  output logic burst_chop,
  output logic [1:0] mr_sel,
  output logic [`DCAP_ADDR_W-1:0] mr_opcode,
  output logic [`DCAP_NUM_BANKS-1:0] open_banks,
  // power and termination
  output dcap_pkg::dcap_pwr_t pwr_state,
  output logic core_clk_en,
  output logic term_on,
  output logic [`DCAP_DQ_W-1:0] term_dq_mask,
  output logic term_strobe,
  output logic term_tdqs,
  output logic strobe_ref,
  // write byte enables
  output logic wr_lo_en,
  output logic wr_hi_en
);
  localparam int ORG = `DCAP_ORG;

  logic [`DCAP_SYNC_W-1:0] pins_raw;
  logic [`DCAP_SYNC_W-1:0] pins;
  logic s_ck;
  logic s_cke;
  logic s_cs_n;
  logic s_ras_n;
  logic s_cas_n;
  logic s_we_n;
  logic [`DCAP_BANK_W-1:0] s_ba;
  logic [`DCAP_ADDR_W-1:0] s_addr;
  logic s_odt;
  logic s_ldm;
  logic s_udm;
  logic ck_prev;
  logic ck_rise;
  logic ck_fall;
  dcap_pkg::dcap_cmd_t next_cmd;
  logic cmd_listen;
  logic [`DCAP_ADDR_W-1:0] mode_reg [`DCAP_NUM_MR];
  logic otf_en;
  logic odt_en;
  logic tdqs_en;
  logic write_act;

  assign pins_raw = {ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, ldm, udm};

  dcap_sync2 #(
    .W(`DCAP_SYNC_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .d(pins_raw),
    .q(pins)
  );

  assign {s_ck, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_ba, s_addr, s_odt, s_ldm, s_udm} = pins;

  // link clock edge finder: all pins share the same sync depth, so they
  // line up with the crossing; the controller holds them from half a link period before the rising crossing until the falling one
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ck_prev <= 1'b0;
    end else begin
      ck_prev <= s_ck;
    end
  end

  assign ck_rise = s_ck & ~ck_prev;
  assign ck_fall = ~s_ck & ck_prev;

  // strobe reference pulses on each crossing of the clock pair
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strobe_ref <= 1'b0;
    end else begin
      strobe_ref <= ck_rise | ck_fall;
    end
  end

  // command decode from the four strobes taken at one crossing
  always_comb begin
    if (s_cs_n) begin
      next_cmd = dcap_pkg::CMD_DESEL;
    end else begin
      case ({s_ras_n, s_cas_n, s_we_n})
        3'h0: next_cmd = dcap_pkg::CMD_LMR;
        3'h1: next_cmd = dcap_pkg::CMD_REF;
        3'h2: next_cmd = dcap_pkg::CMD_PRE;
        3'h3: next_cmd = dcap_pkg::CMD_ACT;
        3'h4: next_cmd = dcap_pkg::CMD_WRITE;
        3'h5: next_cmd = dcap_pkg::CMD_READ;
        3'h6: next_cmd = dcap_pkg::CMD_ZQ;
        default: next_cmd = dcap_pkg::CMD_NOP;
      endcase
    end
  end

  // command inputs are only listened to while awake with clock enable high
  assign cmd_listen = ck_rise && s_cke && (pwr_state == dcap_pkg::PWR_ACTIVE);

  // command register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmd_valid <= 1'b0;
      cmd_code <= dcap_pkg::CMD_NOP;
      cmd_bank <= '0;
      row_addr <= '0;
      col_addr <= '0;
      auto_pre <= 1'b0;
      pre_all <= 1'b0;
      burst_chop <= 1'b0;
      mr_sel <= 2'h0;
      mr_opcode <= '0;
    end else begin
      cmd_valid <= 1'b0;
      if (cmd_listen && next_cmd != dcap_pkg::CMD_DESEL && next_cmd != dcap_pkg::CMD_NOP) begin
        cmd_valid <= 1'b1;
        cmd_code <= next_cmd;
        cmd_bank <= s_ba;
        auto_pre <= 1'b0;
        pre_all <= 1'b0;
        burst_chop <= 1'b0;
        case (next_cmd)
          dcap_pkg::CMD_ACT: begin
            row_addr <= s_addr;
          end
          dcap_pkg::CMD_READ, dcap_pkg::CMD_WRITE: begin
            col_addr <= s_addr[`DCAP_COL_W-1:0];
            auto_pre <= s_addr[`DCAP_AP_BIT];
            burst_chop <= otf_en & ~s_addr[`DCAP_BC_BIT];
          end
          dcap_pkg::CMD_PRE: begin
            pre_all <= s_addr[`DCAP_AP_BIT];
          end
          dcap_pkg::CMD_LMR: begin
            mr_sel <= s_ba[1:0];
            mr_opcode <= s_addr;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // mode registers; only those fields this port needs are read back
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `DCAP_NUM_MR; i++) begin
        mode_reg[i] <= `DCAP_MR_RST;
      end
    end else if (cmd_listen && next_cmd == dcap_pkg::CMD_LMR && s_ba[2] == 1'b0) begin
      mode_reg[s_ba[1:0]] <= s_addr;
    end
  end

  assign otf_en = mode_reg[`DCAP_OTF_MR][`DCAP_OTF_BIT];
  assign tdqs_en = mode_reg[`DCAP_ODT_MR][`DCAP_TDQS_BIT];

  // termination enable latch, loaded by load mode into its register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      odt_en <= `DCAP_ODT_EN_RST;
    end else if (cmd_listen && next_cmd == dcap_pkg::CMD_LMR && s_ba == {1'b0, `DCAP_ODT_MR}) begin
      odt_en <= s_addr[`DCAP_ODT_BIT];
    end
  end

  // open bank tracking, needed to choose between the two power-down kinds
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      open_banks <= '0;
    end else if (cmd_listen) begin
      case (next_cmd)
        dcap_pkg::CMD_ACT: open_banks[s_ba] <= 1'b1;
        dcap_pkg::CMD_PRE: begin
          if (s_addr[`DCAP_AP_BIT]) begin
            open_banks <= '0;
          end else begin
            open_banks[s_ba] <= 1'b0;
          end
        end
        dcap_pkg::CMD_READ, dcap_pkg::CMD_WRITE: begin
          if (s_addr[`DCAP_AP_BIT]) begin
            open_banks[s_ba] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // power state machine
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pwr_state <= dcap_pkg::PWR_ACTIVE;
    end else begin
      case (pwr_state)
        dcap_pkg::PWR_ACTIVE: begin
          if (ck_rise && !s_cke) begin
            if (!s_cs_n && next_cmd == dcap_pkg::CMD_REF && open_banks == '0) begin
              pwr_state <= dcap_pkg::PWR_SELF_REF;
            end else if (open_banks == '0) begin
              pwr_state <= dcap_pkg::PWR_PRE_PD;
            end else begin
              pwr_state <= dcap_pkg::PWR_ACT_PD;
            end
          end
        end
        dcap_pkg::PWR_PRE_PD, dcap_pkg::PWR_ACT_PD: begin
          if (ck_rise && s_cke) begin
            pwr_state <= dcap_pkg::PWR_ACTIVE;
          end
        end
        dcap_pkg::PWR_SELF_REF: begin
          // exit needs no link clock edge: the pair may be stopped here
          if (s_cke) begin
            pwr_state <= dcap_pkg::PWR_ACTIVE;
          end
        end
        default: pwr_state <= dcap_pkg::PWR_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      core_clk_en <= 1'b1;
    end else begin
      core_clk_en <= (pwr_state == dcap_pkg::PWR_ACTIVE);
    end
  end

  // on-die termination; self refresh shuts the odt buffer off
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      term_on <= 1'b0;
    end else if (!odt_en || pwr_state == dcap_pkg::PWR_SELF_REF) begin
      term_on <= 1'b0;
    end else if (ck_rise) begin
      term_on <= s_odt;
    end
  end

  // lanes covered by termination depend on the organisation
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      term_dq_mask <= '0;
      term_strobe <= 1'b0;
      term_tdqs <= 1'b0;
    end else begin
      term_strobe <= term_on;
      term_tdqs <= term_on && ORG == 8 && tdqs_en;
      if (!term_on) begin
        term_dq_mask <= '0;
      end else if (ORG == 4) begin
        term_dq_mask <= 16'h000F;
      end else if (ORG == 8) begin
        term_dq_mask <= 16'h00FF;
      end else begin
        term_dq_mask <= 16'hFFFF;
      end
    end
  end

  // a write is in flight from its command until the next command is taken
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      write_act <= 1'b0;
    end else if (cmd_valid) begin
      write_act <= (cmd_code == dcap_pkg::CMD_WRITE);
    end
  end

  // byte masks: a high mask with a beat blocks that byte from the array
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_lo_en <= 1'b0;
      wr_hi_en <= 1'b0;
    end else begin
      wr_lo_en <= wr_beat && write_act && !s_ldm;
      wr_hi_en <= wr_beat && write_act && !s_udm;
    end
  end

  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_desel_masks: assert property ((ck_rise && s_cs_n) |=> !cmd_valid)
    else $error("command taken with chip select high");

  a_cmd_on_edge: assert property (cmd_valid |-> $past(ck_rise) && $past(s_cke))
    else $error("command taken away from a rising crossing");

  a_act_row: assert property ((cmd_listen && next_cmd == dcap_pkg::CMD_ACT)
    |=> cmd_valid && row_addr == $past(s_addr) && cmd_bank == $past(s_ba))
    else $error("activate row or bank not captured");

  a_ap_bit: assert property ((cmd_listen && next_cmd == dcap_pkg::CMD_READ)
    |=> auto_pre == $past(s_addr[`DCAP_AP_BIT]) && !pre_all)
    else $error("auto precharge bit wrong on read");

  a_pre_all: assert property ((cmd_listen && next_cmd == dcap_pkg::CMD_PRE
    && s_addr[`DCAP_AP_BIT]) |=> open_banks == '0 && pre_all)
    else $error("precharge all left a bank open");

  a_chop_sel: assert property ((cmd_listen && next_cmd == dcap_pkg::CMD_WRITE)
    |=> burst_chop == ($past(otf_en) && !$past(s_addr[`DCAP_BC_BIT])))
    else $error("burst chop selection wrong");

  a_lmr_sel: assert property ((cmd_listen && next_cmd == dcap_pkg::CMD_LMR)
    |=> mr_sel == $past(s_ba[1:0]) && mr_opcode == $past(s_addr))
    else $error("mode register select or op-code wrong");

  a_pd_entry: assert property ((pwr_state == dcap_pkg::PWR_ACTIVE && ck_rise && !s_cke
    && open_banks != '0) |=> pwr_state == dcap_pkg::PWR_ACT_PD)
    else $error("active power-down not entered");

  a_sr_exit: assert property ((pwr_state == dcap_pkg::PWR_SELF_REF && s_cke)
    |=> pwr_state == dcap_pkg::PWR_ACTIVE ##1 core_clk_en)
    else $error("self refresh exit not clockless");

  a_odt_off: assert property ((!odt_en) |=> !term_on ##1 term_dq_mask == '0)
    else $error("termination on while disabled");

  a_pd_quiet: assert property ((pwr_state != dcap_pkg::PWR_ACTIVE) |=> !cmd_valid)
    else $error("command decoded in power-down");

  a_lo_mask: assert property ((wr_beat && write_act && s_ldm) |=> !wr_lo_en)
    else $error("masked lower byte stored");

  a_hi_mask: assert property ((wr_beat && write_act && s_udm) |=> !wr_hi_en)
    else $error("masked upper byte stored");

  a_term_lanes: assert property ((term_on && ORG == 16) |=> term_dq_mask == 16'hFFFF)
    else $error("x16 termination lanes wrong");
endmodule

// [dcap_sync2.sv]
// two flip-flop synchroniser for a bundle of pin levels
module dcap_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// [tb_dcap_port.sv]
// self-checking bench for the dram command and address port
`include "dcap_defs.svh"
module tb_dcap_port;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {dcap_pkg::dcap_cmd_t code; int bank, row, col, ap, bc, mrs, op, ob;} dcap_exp_t;
  logic clk_sys = 0;
  logic resetn = 0;
  logic wr_beat = 0;
  logic ck, cke, cs_n, ras_n, cas_n, we_n, odt, ldm, udm;
  logic [2:0] ba;
  logic [15:0] addr;
  logic cmd_valid, auto_pre, pre_all, burst_chop, core_clk_en, term_on, term_strobe;
  logic term_tdqs, strobe_ref, wr_lo_en, wr_hi_en;
  dcap_pkg::dcap_cmd_t cmd_code;
  dcap_pkg::dcap_pwr_t pwr_state;
  logic [2:0] cmd_bank;
  logic [15:0] row_addr, mr_opcode, term_dq_mask;
  logic [9:0] col_addr;
  logic [1:0] mr_sel;
  logic [7:0] open_banks;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  int strobes = 0;
  // bench model state: open rows, power state, mode-register derived enables
  int ob = 0;
  int pwr = 0;
  int otf = 0;
  int odt_en = 1;
  dcap_exp_t q[$];
  dcap_pkg::dcap_cmd_t tbl[8] = '{dcap_pkg::CMD_LMR, dcap_pkg::CMD_REF, dcap_pkg::CMD_PRE,
    dcap_pkg::CMD_ACT, dcap_pkg::CMD_WRITE, dcap_pkg::CMD_READ, dcap_pkg::CMD_ZQ, dcap_pkg::CMD_NOP};

  dcap_ctrl_model i_ctrl (.clk_sys(clk_sys), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .ldm(ldm), .udm(udm));
  dcap_port i_dut (.clk_sys(clk_sys), .resetn(resetn), .ck(ck), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .ldm(ldm),
    .udm(udm), .wr_beat(wr_beat), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_bank(cmd_bank), .row_addr(row_addr), .col_addr(col_addr), .auto_pre(auto_pre),
    .pre_all(pre_all), .burst_chop(burst_chop), .mr_sel(mr_sel), .mr_opcode(mr_opcode),
    .open_banks(open_banks), .pwr_state(pwr_state), .core_clk_en(core_clk_en),
    .term_on(term_on), .term_dq_mask(term_dq_mask), .term_strobe(term_strobe),
    .term_tdqs(term_tdqs), .strobe_ref(strobe_ref), .wr_lo_en(wr_lo_en), .wr_hi_en(wr_hi_en));

  always #50 clk_sys = ~clk_sys;

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cmd();
    dcap_exp_t x;
    if (q.size() == 0) begin
      chk("unexpected command", 1, 0);
      return;
    end
    x = q.pop_front();
    chk("code", 32'(cmd_code), 32'(x.code));
    chk("open rows", 32'(open_banks), x.ob);
    case (x.code)
      dcap_pkg::CMD_ACT: chk("row", {cmd_bank, row_addr}, {x.bank[2:0], x.row[15:0]});
      dcap_pkg::CMD_READ, dcap_pkg::CMD_WRITE: chk("column", {cmd_bank, burst_chop, auto_pre,
        col_addr}, {x.bank[2:0], x.bc[0], x.ap[0], x.col[9:0]});
      dcap_pkg::CMD_PRE: chk("precharge", {pre_all, pre_all ? 3'h0 : cmd_bank},
        {x.ap[0], x.ap[0] ? 3'h0 : x.bank[2:0]});
      dcap_pkg::CMD_LMR: chk("mode load", {mr_sel, mr_opcode}, {x.mrs[1:0], x.op[15:0]});
      default: ;
    endcase
  endtask

  task automatic chk_state(input logic t);
    logic term;
    term = t && odt_en != 0 && pwr != 3;
    chk("power", 32'(pwr_state), pwr);
    chk("core clock", 32'(core_clk_en), pwr == 0);
    chk("term", 32'(term_on), term);
    chk("lanes", {term_tdqs, term_strobe, term_dq_mask}, {1'b0, term, {16{term}}});
  endtask

  task automatic send(input logic c, input logic [2:0] rcw, input logic [2:0] b,
                      input logic [15:0] a, input logic e, input logic t);
    dcap_exp_t x;
    x = '{tbl[rcw], b, a, a[9:0], a[10], otf & !a[12], b[1:0], a, 0};
    if (pwr != 0) begin
      if (e) pwr = 0;
    end else if (!e) begin
      pwr = (!c && rcw == 3'h1 && ob == 0) ? 3 : (ob == 0 ? 1 : 2);
    end else if (!c && rcw != 3'h7) begin
      case (rcw)
        3'h0: if (!b[2] && b[1:0] == 2'h0) otf = a[0];
          else if (!b[2] && b[1:0] == 2'h1) odt_en = a[2];
        3'h2: ob = a[10] ? 0 : ob & ~(1 << b);
        3'h3: ob = ob | (1 << b);
        3'h4, 3'h5: if (a[10]) ob = ob & ~(1 << b);
        default: ;
      endcase
      x.ob = ob;
      q.push_back(x);
    end
    i_ctrl.drive(c, rcw, b, a, e, t);
    i_ctrl.pulse();
    chk_state(t);
  endtask

  task automatic beat(input logic lo, input logic hi, input logic act);
    i_ctrl.set_mask(lo, hi);
    repeat (3) @(negedge clk_sys);
    wr_beat = 1;
    @(negedge clk_sys);
    wr_beat = 0;
    chk("byte enables", {wr_hi_en, wr_lo_en}, {act & !hi, act & !lo});
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(negedge clk_sys) begin
    if (resetn && cmd_valid === 1'b1) chk_cmd();
    if (strobe_ref === 1'b1) strobes++;
  end

  // generous ceiling: the whole sequence needs well under a thousand link frames
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("BAD t=%0t timeout", $time);
      stop_test();
    end
  end

  initial begin
    logic [2:0] rcw;
    void'($urandom(32'hC14DEDE4));
    repeat (3) @(negedge clk_sys);
    resetn = 1;
    chk_state(0);
    repeat (3) @(negedge clk_sys);
    $display("test reset done");
    for (int i = 0; i < 48; i++) begin
      rcw = (i < 8) ? i[2:0] : 3'($urandom % 8);
      send(i >= 8 && $urandom % 4 == 0, rcw, 3'($urandom), 16'($urandom), 1, rcw != 0 && $urandom % 2);
    end
    $display("test commands done");
    send(0, 3'h0, 3'h0, 16'h0001, 1, 0);
    send(0, 3'h5, 3'h2, 16'h0000, 1, 0);
    send(0, 3'h5, 3'h2, 16'h1000, 1, 0);
    send(0, 3'h0, 3'h1, 16'h0000, 1, 0);
    send(1, 3'h7, 3'h0, 16'h0000, 1, 1);
    send(0, 3'h0, 3'h1, 16'h0004, 1, 0);
    send(1, 3'h7, 3'h0, 16'h0000, 1, 1);
    $display("test chop and termination done");
    send(0, 3'h4, 3'h1, 16'h0000, 1, 0);
    for (int m = 0; m < 4; m++) beat(m[0], m[1], 1);
    send(0, 3'h3, 3'h5, 16'h0123, 1, 0);
    beat(0, 0, 0);
    $display("test write masks done");
    send(1, 3'h7, 3'h0, 16'h0000, 0, 0);
    send(0, 3'h3, 3'h2, 16'h0042, 0, 1);
    send(1, 3'h7, 3'h0, 16'h0000, 1, 0);
    send(0, 3'h2, 3'h0, 16'h0400, 1, 0);
    send(1, 3'h7, 3'h0, 16'h0000, 0, 0);
    send(1, 3'h7, 3'h0, 16'h0000, 1, 0);
    send(0, 3'h1, 3'h0, 16'h0000, 0, 1);
    i_ctrl.drive(1, 3'h7, 3'h0, 16'h0000, 1, 0);
    pwr = 0;
    repeat (6) @(negedge clk_sys);
    chk("self refresh exit", 32'(pwr_state), 0);
    i_ctrl.pulse();
    chk("strobe reference", strobes, i_ctrl.edges);
    $display("test power done");
    send(0, 3'h3, 3'h6, 16'h0077, 1, 0);
    @(negedge clk_sys);
    resetn = 0;
    #10 chk("async reset", {open_banks, cmd_code, pwr_state},
      {8'h00, dcap_pkg::CMD_NOP, dcap_pkg::PWR_ACTIVE});
    @(negedge clk_sys);
    resetn = 1;
    ob = 0;
    otf = 0;
    odt_en = 1;
    repeat (3) @(negedge clk_sys);
    send(0, 3'h3, 3'h0, 16'h1234, 1, 0);
    chk("pending commands", q.size(), 0);
    $display("test reset in flight done");
    stop_test();
  end
endmodule
